/* File: tb/lbk_profile_b_properties.sv */
`timescale 1ns/100ps
module lbk_profile_b_properties #(parameter int OBS_CYCLE_CLKS = 4) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire lbk_pkg::lbk_reg_req_s regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    input wire logic faultSeen,
    input wire logic alarmActive,
    input wire logic [7:0] bucketLevel,
    input wire logic obsCycleEnd
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence cycClose;
        obsCycleEnd ##1 !obsCycleEnd;
    endsequence
    AST_HOLD: assert property (!obsCycleEnd |-> $stable(bucketLevel))
        else $error("level moved off cycle end");
    AST_PULSE: assert property (obsCycleEnd |-> cycClose)
        else $error("cycle end pulse too long");
    AST_STEP: assert property (obsCycleEnd |-> bucketLevel <= 9'($past(bucketLevel)) + 9'h001)
        else $error("level rose by more than one");
    AST_FLOOR: assert property (obsCycleEnd && $past(bucketLevel) == 8'h00 |-> bucketLevel <= 8'h01)
        else $error("level wrapped below zero");
    AST_RISE: assert property ($rose(alarmActive) |-> $past(obsCycleEnd) || $past(regReq.wr))
        else $error("alarm rose off cycle end");
    AST_FALL: assert property ($fell(alarmActive) |-> $past(obsCycleEnd) || $past(regReq.wr))
        else $error("alarm fell off cycle end");
    AST_RVALID: assert property (regRvalid == $past(regReq.rd))
        else $error("read answer misplaced");
endmodule
bind lbk_profile_b lbk_profile_b_properties #(.OBS_CYCLE_CLKS(OBS_CYCLE_CLKS)) chkr (
    .core_clk(core_clk), .reset_n(reset_n), .regReq(regReq), .regRdata(regRdata),
    .regRvalid(regRvalid), .faultSeen(faultSeen), .alarmActive(alarmActive),
    .bucketLevel(bucketLevel), .obsCycleEnd(obsCycleEnd));

/* File: tb/lbk_profile_b_tb_top.sv */
`timescale 1ns/100ps
module lbk_profile_b_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    lbk_pkg::lbk_reg_req_s regReq = '0;
    logic faultSeen = 1'b0;
    logic [7:0] regRdata, bucketLevel;
    logic regRvalid, alarmActive, obsCycleEnd;
    logic [7:0] rstVal [5] = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h00};
    int err_total = 0;
    int checked = 0;
    int tick = 0;
    always #2.5 core_clk = ~core_clk;
    // short observation cycle keeps the run small
    lbk_profile_b #(.OBS_CYCLE_CLKS(4)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .faultSeen(faultSeen),
        .alarmActive(alarmActive), .bucketLevel(bucketLevel), .obsCycleEnd(obsCycleEnd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        regReq = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk({7'h00, regRvalid}, 8'h01);
        chk(regRdata, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge obsCycleEnd);
            @(negedge core_clk);
        end
    endtask
    task automatic t_regs;
        for (int i = 0; i < 5; i++) rd(8'h54 + 8'(i), rstVal[i]);
        acc(1'b1, 8'h54, 8'ha5);
        rd(8'h54, 8'ha5);
    endtask
    task automatic t_bucket;
        acc(1'b1, 8'h54, 8'h03);
        acc(1'b1, 8'h55, 8'h01);
        acc(1'b1, 8'h56, 8'h04);
        acc(1'b1, 8'h57, 8'h00);
        faultSeen = 1'b1;
        cyc(6);
        chk(bucketLevel, 8'h04);
        faultSeen = 1'b0;
        @(negedge core_clk);
        chk({7'h00, alarmActive}, 8'h01);
        cyc(2);
        chk({7'h00, alarmActive}, 8'h01);
        cyc(1);
        @(negedge core_clk);
        chk({7'h00, alarmActive}, 8'h00);
        cyc(2);
        chk(bucketLevel, 8'h00);
    endtask
    task automatic t_decay;
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 8'h57, 8'(c));
            faultSeen = 1'b1;
            cyc(1);
            faultSeen = 1'b0;
            chk(bucketLevel, 8'h01);
            cyc((1 << c) - 1);
            chk(bucketLevel, 8'h01);
            cyc(1);
            chk(bucketLevel, 8'h00);
        end
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        t_regs();
        t_bucket();
        t_decay();
        test_done();
    end
    always @(posedge core_clk) begin
        tick <= tick + 1;
        if (tick == 3000) begin
            err_total++;
            test_done();
        end
    end
endmodule

/* File: verilog/lbk_pkg.sv */
// Overview of operation
// RL1: each 128 ms observation cycle in which the input failed or was erratic adds one to its accumulator.
// RL2: each fault-free period of 1, 2, 4 or 8 cycles, chosen by the decay-rate setting, takes one away.
// RL3: an 8-bit read/write alarm set limit, reset to 6, raises the alarm once the count reaches it.
// RL4: an 8-bit read/write alarm reset limit, reset to 4, clears the alarm once the count falls to it.
// RL5: an 8-bit read/write accumulator ceiling, reset to 8, is a count the accumulator never exceeds; the code clamps only at a faulty cycle end.
// RL6: decay codes 00, 01, 10 and 11 give one decrement per 128, 256, 512 or 1024 ms fault-free.
// RL7: a decrement that falls due while the count is zero leaves it at zero.
package lbk_pkg;

    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int OBS_CYCLE_MS = 128;
    localparam int OBS_CYCLE_CLKS = (CLK_FREQ_HZ / 1000) * OBS_CYCLE_MS;

    localparam logic [7:0] RAISE_LIMIT_ADDR = 8'h54;
    localparam logic [7:0] CLEAR_LIMIT_ADDR = 8'h55;
    localparam logic [7:0] CEILING_ADDR = 8'h56;
    localparam logic [7:0] DECAY_RATE_ADDR = 8'h57;

    localparam logic [7:0] RAISE_LIMIT_RESET = 8'h06;
    localparam logic [7:0] CLEAR_LIMIT_RESET = 8'h04;
    localparam logic [7:0] CEILING_RESET = 8'h08;
    localparam logic [1:0] DECAY_RATE_RESET = 2'h1;

    localparam int DECAY_RATE_LSB = 0;
    localparam int DECAY_RATE_WIDTH = 2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lbk_reg_req_s;

endpackage

/* File: verilog/lbk_profile_b.sv */
`timescale 1ns/100ps
module lbk_profile_b #(
    parameter int OBS_CYCLE_CLKS = lbk_pkg::OBS_CYCLE_CLKS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire lbk_pkg::lbk_reg_req_s regReq,
    output logic [7:0] regRdata,
    output logic regRvalid,
    input wire logic faultSeen,
    output logic alarmActive,
    output logic [7:0] bucketLevel,
    output logic obsCycleEnd
);

    // fault-free cycles needed per decrement
    function automatic logic [3:0] decayPeriod(input logic [1:0] code);
        case (code)
            2'h0: decayPeriod = 4'h1;
            2'h1: decayPeriod = 4'h2;
            2'h2: decayPeriod = 4'h4;
            default: decayPeriod = 4'h8;
        endcase
    endfunction

    // one-hot register select, shared by the write and the read path
    function automatic logic [3:0] regSel(input logic [7:0] addr);
        case (addr)
            lbk_pkg::RAISE_LIMIT_ADDR: regSel = 4'h1;
            lbk_pkg::CLEAR_LIMIT_ADDR: regSel = 4'h2;
            lbk_pkg::CEILING_ADDR: regSel = 4'h4;
            lbk_pkg::DECAY_RATE_ADDR: regSel = 4'h8;
            default: regSel = 4'h0;
        endcase
    endfunction

    logic [7:0] raiseLimit_r, raiseLimit_nxt;
    logic [7:0] clearLimit_r, clearLimit_nxt;
    logic [7:0] ceiling_r, ceiling_nxt;
    logic [1:0] decayRate_r, decayRate_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [3:0] sel;

    always_comb begin
        sel = regSel(regReq.addr);
        raiseLimit_nxt = raiseLimit_r;
        clearLimit_nxt = clearLimit_r;
        ceiling_nxt = ceiling_r;
        decayRate_nxt = decayRate_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = regReq.rd;
        // writes to unmapped addresses fall through untouched
        if (regReq.wr) begin
            // RL3 set limit write
            if (sel[0]) begin
                raiseLimit_nxt = regReq.wdata;
            end
            // RL4 reset limit write
            if (sel[1]) begin
                clearLimit_nxt = regReq.wdata;
            end
            // RL5 ceiling write
            if (sel[2]) begin
                ceiling_nxt = regReq.wdata;
            end
            // RL6 decay code write, upper bits ignored
            if (sel[3]) begin
                decayRate_nxt = regReq.wdata[lbk_pkg::DECAY_RATE_LSB +: lbk_pkg::DECAY_RATE_WIDTH];
            end
        end
        // a read in the same cycle as a write returns the old value
        if (regReq.rd) begin
            rdata_nxt = 8'h00;
            if (sel[0]) begin
                rdata_nxt = raiseLimit_r;
            end
            if (sel[1]) begin
                rdata_nxt = clearLimit_r;
            end
            if (sel[2]) begin
                rdata_nxt = ceiling_r;
            end
            // unused bits of the decay register read as zero
            if (sel[3]) begin
                rdata_nxt = {6'h00, decayRate_r};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            raiseLimit_r <= lbk_pkg::RAISE_LIMIT_RESET;
            clearLimit_r <= lbk_pkg::CLEAR_LIMIT_RESET;
            ceiling_r <= lbk_pkg::CEILING_RESET;
            decayRate_r <= lbk_pkg::DECAY_RATE_RESET;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            raiseLimit_r <= raiseLimit_nxt;
            clearLimit_r <= clearLimit_nxt;
            ceiling_r <= ceiling_nxt;
            decayRate_r <= decayRate_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // observation timer: one enable pulse per observation cycle
    logic [31:0] obsCnt_r, obsCnt_nxt;
    logic obsEnd_r, obsEnd_nxt;
    logic faultHeld_r, faultHeld_nxt;
    logic lastCycle;
    logic cycFaulty;

    always_comb begin
        lastCycle = (obsCnt_r == 32'(OBS_CYCLE_CLKS - 1));
        // a fault anywhere in the cycle, even on its last clock, counts
        cycFaulty = faultHeld_r | faultSeen;
        obsCnt_nxt = obsCnt_r + 32'h1;
        faultHeld_nxt = cycFaulty;
        if (lastCycle) begin
            obsCnt_nxt = 32'h0;
            faultHeld_nxt = 1'b0;
        end
        obsEnd_nxt = lastCycle;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            obsCnt_r <= 32'h0;
            obsEnd_r <= 1'b0;
            faultHeld_r <= 1'b0;
        end else begin
            obsCnt_r <= obsCnt_nxt;
            obsEnd_r <= obsEnd_nxt;
            faultHeld_r <= faultHeld_nxt;
        end
    end

    // accumulator and its fault-free run counter
    logic [3:0] quietCnt_r, quietCnt_nxt;
    logic [7:0] bucket_r, bucket_nxt;
    logic leakDue;

    always_comb begin
        // RL6 period from decay code
        leakDue = (quietCnt_r + 4'h1) >= decayPeriod(decayRate_r);
        quietCnt_nxt = quietCnt_r;
        bucket_nxt = bucket_r;
        if (lastCycle) begin
            if (cycFaulty) begin
                // a faulty cycle restarts the fault-free run
                quietCnt_nxt = 4'h0;
                // RL5 clamp at ceiling, also if the ceiling was lowered
                if (bucket_r >= ceiling_r) begin
                    bucket_nxt = ceiling_r;
                end else begin
                    // RL1 fill on fault
                    bucket_nxt = bucket_r + 8'h01;
                end
            end else begin
                // RL2 leak after quiet period
                if (leakDue) begin
                    quietCnt_nxt = 4'h0;
                    // RL7 hold at zero
                    if (bucket_r != 8'h00) begin
                        bucket_nxt = bucket_r - 8'h01;
                    end
                end else begin
                    quietCnt_nxt = quietCnt_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            quietCnt_r <= 4'h0;
            bucket_r <= 8'h00;
        end else begin
            quietCnt_r <= quietCnt_nxt;
            bucket_r <= bucket_nxt;
        end
    end

    // alarm follows the registered count one clock later
    logic alarm_r, alarm_nxt;

    always_comb begin
        alarm_nxt = alarm_r;
        // RL3 raise on reaching set limit
        if (!alarm_r && bucket_r >= raiseLimit_r) begin
            alarm_nxt = 1'b1;
        end
        // RL4 clear at reset limit
        if (alarm_r && bucket_r <= clearLimit_r) begin
            alarm_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    assign regRdata = rdata_r;
    assign regRvalid = rvalid_r;
    assign alarmActive = alarm_r;
    assign bucketLevel = bucket_r;
    assign obsCycleEnd = obsEnd_r;

endmodule
